// ===== pkg/spc_pkg.sv
// Shared constants and types of the sleep and idle power controller
package spc_pkg;
	localparam logic SPC_MODE_SLEEP = 1'h0;
	localparam logic SPC_MODE_IDLE = 1'h1;
	localparam int SPC_IRQ_COUNT = 16;
	localparam int SPC_SRC_WIDTH = 3;
	localparam logic [2:0] SPC_SRC_RESET = 3'h0;
	localparam int SPC_OSC_STOP_TIME_NS = 20;
	localparam int SPC_CLOCK_PERIOD_NS = 5;
	localparam logic [3:0] SPC_OSC_STOP_CYCLES = 4'(
		(SPC_OSC_STOP_TIME_NS + SPC_CLOCK_PERIOD_NS - 1) /
		SPC_CLOCK_PERIOD_NS);
	localparam int SPC_OSC_START_TIME_NS = 40;
	localparam logic [3:0] SPC_OSC_START_CYCLES = 4'(
		(SPC_OSC_START_TIME_NS + SPC_CLOCK_PERIOD_NS - 1) /
		SPC_CLOCK_PERIOD_NS);

	typedef enum logic [2:0] {
		SPC_RUN = 3'b000,
		SPC_ENTER = 3'b001,
		SPC_SLEEP = 3'b010,
		SPC_IDLE = 3'b011,
		SPC_WAKE = 3'b100
	} spc_state_type;
endpackage : spc_pkg

// ===== pkg/spc_wake_if.sv
// Wake-event bundle between the wake detector and the sequencer
interface spc_wake_if;
	logic wake;
	logic irq_wake;
	logic wdt_wake;
	modport source (output wake, output irq_wake, output wdt_wake);
	modport sink (input wake, input irq_wake, input wdt_wake);
endinterface : spc_wake_if

// ===== design/spc_sync.sv
// Two-stage synchroniser for one bit of pin level
module spc_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Data
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic first;
		logic second;
	} spc_sync_state_type;

	spc_sync_state_type state;
	spc_sync_state_type next_state;

	always_comb begin
		next_state.first = din;
		next_state.second = state.first;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign dout = state.second;
endmodule : spc_sync

// ===== design/spc_wake_detect.sv
// Wake detection from enabled interrupt requests and watchdog time-out
module spc_wake_detect
	import spc_pkg::*;
#(
	parameter int IRQ_COUNT = SPC_IRQ_COUNT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Sources
	input wire logic [IRQ_COUNT-1:0] irq_request,
	input wire logic [IRQ_COUNT-1:0] irq_enable,
	input wire logic watchdog_timeout,
	// Result
	spc_wake_if.source wake_bus
);
	typedef struct packed {
		logic irq;
		logic wdt;
	} spc_wd_state_type;

	spc_wd_state_type state;
	spc_wd_state_type next_state;
	logic [IRQ_COUNT-1:0] hit;

	genvar i;
	generate
		for (i = 0; i < IRQ_COUNT; i++) begin : g_hit
			assign hit[i] = irq_request[i] & irq_enable[i];
		end
	endgenerate

	always_comb begin
		next_state.irq = |hit;
		next_state.wdt = watchdog_timeout;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign wake_bus.irq_wake = state.irq;
	assign wake_bus.wdt_wake = state.wdt;
	assign wake_bus.wake = state.irq | state.wdt;
endmodule : spc_wake_detect

// ===== design/spc_power_ctrl.sv
// Sleep and idle power controller: sequencing and clock gating

module spc_power_ctrl
	import spc_pkg::*;
#(
	parameter int IRQ_COUNT = SPC_IRQ_COUNT,
	parameter int SRC_WIDTH = SPC_SRC_WIDTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Instruction decode
	input wire logic power_save_instruction,
	input wire logic power_save_mode,
	input wire logic instruction_done,
	// Clock configuration
	input wire logic [SRC_WIDTH-1:0] clock_source_select,
	input wire logic source_is_onchip,
	input wire logic watchdog_enable,
	// Wake sources
	input wire logic [IRQ_COUNT-1:0] irq_request,
	input wire logic [IRQ_COUNT-1:0] irq_enable,
	input wire logic watchdog_timeout,
	input wire logic change_notify_pin,
	// Clock gating
	output logic cpu_clock_enable,
	output logic periph_clock_enable,
	output logic ext_periph_clock_enable,
	output logic system_osc_enable,
	output logic onchip_osc_enable,
	output logic low_power_rc_oscillator_enable,
	output logic fail_safe_monitor_enable,
	output logic [SRC_WIDTH-1:0] active_clock_source,
	// Status
	output logic watchdog_counter_clear,
	output logic fetch_enable,
	output logic in_sleep,
	output logic in_idle,
	output logic change_notify_wake
);
	typedef struct packed {
		spc_state_type fsm;
		logic pending;
		logic pending_mode;
		logic [3:0] count;
		logic [SRC_WIDTH-1:0] saved_source;
		logic cpu_en;
		logic per_en;
		logic sys_osc;
		logic chip_osc;
		logic low_power_rc_oscillator;
		logic fscm;
		logic wdt_clr;
		logic fetch;
		logic sleep_flag;
		logic idle_flag;
		logic [SRC_WIDTH-1:0] source_out;
		logic cn_wake;
		logic ext_en;
	} spc_ctrl_state_type;

	spc_ctrl_state_type state;
	spc_ctrl_state_type next_state;
	logic cn_level;
	logic cn_last;
	logic next_cn_last;
	spc_wake_if wake_bus ();

	spc_sync u_cn_sync (
		.clock(clock),
		.rst(rst),
		.din(change_notify_pin),
		.dout(cn_level)
	);

	spc_wake_detect #(
		.IRQ_COUNT(IRQ_COUNT)
	) u_wake (
		.clock(clock),
		.rst(rst),
		.irq_request(irq_request),
		.irq_enable(irq_enable),
		.watchdog_timeout(watchdog_timeout),
		.wake_bus(wake_bus.source)
	);

	// Edge tracker for change notification, kept apart from the struct
	always_comb begin
		next_cn_last = cn_level;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cn_last <= 1'b0;
		end else begin
			cn_last <= next_cn_last;
		end
	end

	always_comb begin
		next_state = state;
		next_state.wdt_clr = 1'b0;
		next_state.cn_wake = 1'b0;
		case (state.fsm)
			SPC_RUN: begin
				next_state.cpu_en = 1'b1;
				next_state.per_en = 1'b1;
				next_state.sys_osc = 1'b1;
				next_state.chip_osc = source_is_onchip;
				next_state.fscm = 1'b1;
				next_state.low_power_rc_oscillator = watchdog_enable;
				next_state.fetch = 1'b1;
				next_state.source_out = clock_source_select;
				// Latch the request; fetch stops so no later opcode slips in
				if (power_save_instruction) begin
					next_state.pending = 1'b1;
					next_state.pending_mode = power_save_mode;
					next_state.fetch = 1'b0;
				end
				if (state.pending && instruction_done) begin
					next_state.pending = 1'b0;
					next_state.fetch = 1'b0;
					next_state.saved_source = clock_source_select;
					if (state.pending_mode == SPC_MODE_IDLE) begin
						next_state.fsm = SPC_IDLE;
						next_state.cpu_en = 1'b0;
						next_state.idle_flag = 1'b1;
					end else begin
						next_state.fsm = SPC_ENTER;
						next_state.cpu_en = 1'b0;
						next_state.count = SPC_OSC_STOP_CYCLES;
						next_state.wdt_clr = watchdog_enable;
					end
				end else if (state.pending) begin
					next_state.fetch = 1'b0;
				end
			end
			SPC_ENTER: begin
				// Peripherals drain before the source stops
				next_state.per_en = 1'b0;
				next_state.fscm = 1'b0;
				if (state.count <= 4'h1) begin
					next_state.fsm = SPC_SLEEP;
					next_state.sys_osc = 1'b0;
					next_state.chip_osc = 1'b0;
					next_state.sleep_flag = 1'b1;
					next_state.low_power_rc_oscillator = watchdog_enable;
				end else begin
					next_state.count = state.count - 4'h1;
				end
			end
			SPC_SLEEP: begin
				next_state.low_power_rc_oscillator = watchdog_enable;
				next_state.fscm = 1'b0;
				next_state.cn_wake = cn_level & ~cn_last;
				if (wake_bus.wake || (cn_level && !cn_last)) begin
					next_state.fsm = SPC_WAKE;
					next_state.sys_osc = 1'b1;
					next_state.chip_osc = source_is_onchip;
					next_state.source_out = state.saved_source;
					next_state.count = SPC_OSC_START_CYCLES;
				end
			end
			SPC_IDLE: begin
				next_state.per_en = 1'b1;
				if (wake_bus.wake) begin
					next_state.fsm = SPC_RUN;
					next_state.cpu_en = 1'b1;
					next_state.fetch = 1'b1;
					next_state.idle_flag = 1'b0;
				end
			end
			SPC_WAKE: begin
				// Hold the CPU until the restarted source has settled
				if (state.count <= 4'h1) begin
					next_state.fsm = SPC_RUN;
					next_state.cpu_en = 1'b1;
					next_state.per_en = 1'b1;
					next_state.fscm = 1'b1;
					next_state.fetch = 1'b1;
					next_state.sleep_flag = 1'b0;
					next_state.source_out = state.saved_source;
				end else begin
					next_state.count = state.count - 4'h1;
				end
			end
			default: begin
				next_state.fsm = SPC_RUN;
			end
		endcase
	end

	// Reset wakes from either state by returning here
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state.fsm <= SPC_RUN;
			state.pending <= 1'b0;
			state.pending_mode <= SPC_MODE_SLEEP;
			state.count <= 4'h0;
			state.saved_source <= SPC_SRC_RESET;
			state.cpu_en <= 1'b1;
			state.per_en <= 1'b1;
			state.sys_osc <= 1'b1;
			state.chip_osc <= 1'b1;
			state.low_power_rc_oscillator <= 1'b0;
			state.fscm <= 1'b1;
			state.wdt_clr <= 1'b0;
			state.fetch <= 1'b1;
			state.sleep_flag <= 1'b0;
			state.idle_flag <= 1'b0;
			state.source_out <= SPC_SRC_RESET;
			state.cn_wake <= 1'b0;
			state.ext_en <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	assign cpu_clock_enable = state.cpu_en;
	assign periph_clock_enable = state.per_en;
	// Externally clocked peripherals never lose their enable
	assign ext_periph_clock_enable = state.ext_en;
	assign system_osc_enable = state.sys_osc;
	assign onchip_osc_enable = state.chip_osc;
	assign low_power_rc_oscillator_enable = state.low_power_rc_oscillator;
	assign fail_safe_monitor_enable = state.fscm;
	assign active_clock_source = state.source_out;
	assign watchdog_counter_clear = state.wdt_clr;
	assign fetch_enable = state.fetch;
	assign in_sleep = state.sleep_flag;
	assign in_idle = state.idle_flag;
	assign change_notify_wake = state.cn_wake;
endmodule : spc_power_ctrl

// ===== tb/spc_power_ctrl_assertions.sv
// Checker of the power controller's port behaviour
module spc_chk
	import spc_pkg::*;
#(
	parameter int IRQ_COUNT = SPC_IRQ_COUNT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic power_save_instruction,
	input wire logic source_is_onchip,
	input wire logic watchdog_enable,
	input wire logic watchdog_timeout,
	input wire logic [IRQ_COUNT-1:0] irq_request,
	input wire logic [IRQ_COUNT-1:0] irq_enable,
	input wire logic cpu_clock_enable,
	input wire logic periph_clock_enable,
	input wire logic ext_periph_clock_enable,
	input wire logic system_osc_enable,
	input wire logic onchip_osc_enable,
	input wire logic low_power_rc_oscillator_enable,
	input wire logic fail_safe_monitor_enable,
	input wire logic watchdog_counter_clear,
	input wire logic fetch_enable,
	input wire logic in_sleep,
	input wire logic in_idle,
	input wire logic change_notify_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	osc_off_a: assert property ($rose(in_sleep) && source_is_onchip
		|-> !system_osc_enable && !onchip_osc_enable) else $error("osc on");
	fscm_off_a: assert property (in_sleep
		|-> !fail_safe_monitor_enable) else $error("monitor on");
	low_power_rc_oscillator_run_a: assert property (in_sleep && watchdog_enable
		&& $stable(watchdog_enable) |-> low_power_rc_oscillator_enable)
		else $error("rc off");
	idle_gate_a: assert property (in_idle |-> !cpu_clock_enable
		&& periph_clock_enable && !fetch_enable) else $error("idle gates");
	ext_run_a: assert property (ext_periph_clock_enable)
		else $error("ext off");
	wdt_clear_a: assert property ($rose(in_sleep) && watchdog_enable
		|-> $past(watchdog_counter_clear, 4)) else $error("no clear");
	fetch_stop_a: assert property ($fell(fetch_enable)
		|-> $past(power_save_instruction)) else $error("stray stop");
	idle_wake_a: assert property (in_idle && |(irq_request & irq_enable)
		|-> ##[1:4] !in_idle) else $error("idle no wake");
	sleep_wake_a: assert property (in_sleep && watchdog_timeout
		|-> ##[1:16] !in_sleep) else $error("sleep no wake");
	cover property ($rose(in_sleep));
	cover property ($rose(in_idle));
	cover property (change_notify_wake);
endmodule : spc_chk

bind spc_power_ctrl spc_chk #(.IRQ_COUNT(IRQ_COUNT)) chk_i (.*);

// ===== tb/spc_power_ctrl_bench.sv
// Directed bench of the sleep and idle power controller
module sleep_idle_power_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import spc_pkg::*;
	logic clock = 0, rst = 1, power_save_instruction = 0;
	logic power_save_mode = 0, instruction_done = 0, source_is_onchip = 1;
	logic watchdog_enable = 0, watchdog_timeout = 0, change_notify_pin = 0;
	logic [2:0] clock_source_select = 3'h0, active_clock_source;
	logic [15:0] irq_request = 16'h0, irq_enable = 16'h0;
	logic cpu_clock_enable, periph_clock_enable, ext_periph_clock_enable;
	logic system_osc_enable, onchip_osc_enable, fail_safe_monitor_enable;
	logic low_power_rc_oscillator_enable, watchdog_counter_clear;
	logic fetch_enable, in_sleep, in_idle, change_notify_wake;
	int bad_count = 0, checks_done = 0, clr_n = 0, cn_n = 0;

	spc_power_ctrl DUT (.*);

	initial forever #2.5 clock = ~clock;
	// Counted at the falling edge, where the registered pulses have settled
	always @(negedge clock) begin
		clr_n += watchdog_counter_clear;
		cn_n += change_notify_wake;
	end

	task print_verdict();
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task chk(input string n, input logic [2:0] e, input logic [2:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// Bounded wait on one of three levels: 0 sleep, 1 idle, 2 oscillator
	task wt(input int s, input logic v);
		int n;
		logic g;
		n = 0;
		g = s == 0 ? in_sleep : s == 1 ? in_idle : system_osc_enable;
		while (g !== v && n < 40) begin
			@(negedge clock);
			n++;
			g = s == 0 ? in_sleep : s == 1 ? in_idle : system_osc_enable;
		end
		chk("level", v, g);
	endtask : wt

	// Done arrives gap cycles late; only fetch may stop before it, the CPU clock runs on
	task enter(input logic m, input int gap);
		@(negedge clock);
		power_save_instruction = 1;
		power_save_mode = m;
		@(negedge clock);
		power_save_instruction = 0;
		chk("fetch", 0, fetch_enable);
		repeat (gap) @(negedge clock);
		chk("cpu early", 1, cpu_clock_enable);
		instruction_done = 1;
		@(negedge clock);
		instruction_done = 0;
	endtask : enter

	task t_idle();
		enter(SPC_MODE_IDLE, 0);
		wt(1, 1);
		chk("idle cpu", 0, cpu_clock_enable);
		chk("idle periph", 1, periph_clock_enable);
		irq_request = 16'h0008;
		repeat (6) @(negedge clock);
		chk("masked", 1, in_idle);
		irq_enable = 16'h0008;
		wt(1, 0);
		chk("cpu back", 1, cpu_clock_enable);
		irq_request = 16'h0000;
		irq_enable = 16'h0000;
	endtask : t_idle

	task t_sleep();
		clock_source_select = 3'h5;
		watchdog_enable = 1;
		enter(SPC_MODE_SLEEP, 3);
		wt(0, 1);
		chk("ext", 1, ext_periph_clock_enable);
		chk("cpu", 0, cpu_clock_enable);
		chk("onchip", 0, onchip_osc_enable);
		chk("fscm", 0, fail_safe_monitor_enable);
		chk("rc", 1, low_power_rc_oscillator_enable);
		chk("clears", 1, 3'(clr_n));
		chk("periph", 0, periph_clock_enable);
		clock_source_select = 3'h2;
		repeat (4) @(negedge clock);
		watchdog_timeout = 1;
		@(negedge clock);
		watchdog_timeout = 0;
		wt(2, 1);
		chk("source", 3'h5, active_clock_source);
		wt(0, 0);
		chk("fetch back", 1, fetch_enable);
	endtask : t_sleep

	task t_notify();
		watchdog_enable = 0;
		enter(SPC_MODE_SLEEP, 0);
		wt(0, 1);
		chk("no clear", 1, 3'(clr_n));
		change_notify_pin = 1;
		wt(0, 0);
		chk("notify", 1, 3'(cn_n));
		change_notify_pin = 0;
	endtask : t_notify

	task t_reset();
		watchdog_enable = 1;
		enter(SPC_MODE_SLEEP, 0);
		wt(0, 1);
		rst = 1;
		@(negedge clock);
		rst = 0;
		chk("rst sleep", 0, in_sleep);
		chk("rst source", SPC_SRC_RESET, active_clock_source);
	endtask : t_reset

	initial begin
		repeat (8) @(negedge clock);
		rst = 0;
		t_idle();
		t_sleep();
		t_notify();
		t_reset();
		print_verdict();
	end

	initial begin
		#20000;
		bad_count++;
		print_verdict();
	end
endmodule : sleep_idle_power_controller_bench
